// ==== design/balu_top.sv ====
// Overview of operation
// - add registers, optional carry, one cycle
// - word add immediate, word flags, two cycles
// - subtract register or constant, one cycle
// - subtract with carry, one cycle
// - word subtract immediate, two cycles
// - conjunction with register or constant
// - disjunction with register or constant
// - bit set by constant mask
// - bit clear by inverted constant mask
// - test register, flags only
// - integer products into pair, two cycles
// - fractional products shifted left, two cycles
// - pointer jump loads counter, two cycles
`timescale 1ns/1ps
`include "balu_params.svh"
module balu_top (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic start,
   input wire balu_pkg::balu_op_e op,
   input wire logic use_const,
   input wire logic [7:0] rd_val,
   input wire logic [7:0] rd_hi_val,
   input wire logic [7:0] rr_val,
   input wire logic [7:0] imm,
   input wire logic [7:0] sreg_in,
   input wire logic [15:0] ptr_val,
   output logic ready,
   output logic done_q,
   output logic [7:0] res_lo_q,
   output logic [7:0] res_hi_q,
   output logic wr_lo_q,
   output logic wr_hi_q,
   output logic to_pair_q,
   output logic [7:0] sreg_q,
   output logic [7:0] sreg_we_q,
   output logic pc_load_q,
   output logic [15:0] pc_q
);
   import balu_pkg::*;

   // add or subtract with carry in; returns {h, v, c, result}
   function automatic logic [10:0] arith8(input logic [7:0] x,
         input logic [7:0] y, input logic cin, input logic sub);
      logic [8:0] s9;
      logic [4:0] s5;
      logic v;
      s9 = sub ? ({1'b0, x} - {1'b0, y} - {8'h00, cin})
               : ({1'b0, x} + {1'b0, y} + {8'h00, cin});
      s5 = sub ? ({1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin})
               : ({1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin});
      v = sub ? ((x[7] & ~y[7] & ~s9[7]) | (~x[7] & y[7] & s9[7]))
              : ((x[7] & y[7] & ~s9[7]) | (~x[7] & ~y[7] & s9[7]));
      arith8 = {s5[4], v, s9[8], s9[7:0]};
   endfunction

   balu_state_e state_q, state_d;
   balu_op_e op_q;
   logic [7:0] src;
   logic [5:0] wimm;
   logic carry_in;
   logic take;
   logic long_op;
   logic prod_op;
   logic fin;
   logic [10:0] ar;
   logic [7:0] res8;
   logic c_n, h_n, v_n, z_keep;
   logic [7:0] msk1;
   logic [7:0] fl1;
   logic [16:0] word_sum;
   logic [15:0] word_q;
   logic [7:0] wfl_q;
   logic [7:0] sreg_lat_q;
   logic [15:0] ptr_q;
   logic [15:0] prod;
   logic prod_c;
   logic [7:0] out_lo, out_hi, out_fl, out_msk, base;
   logic out_wr_lo, out_wr_hi, out_pair, out_jump;
   logic [7:0] sreg_d;

   // operand selection and request acceptance
   assign src = use_const ? imm : rr_val;
   assign wimm = imm[5:0];
   assign carry_in = sreg_in[`BALU_FLAG_C];
   assign ready = (state_q == ST_IDLE);
   assign take = start & ready;
   assign long_op = (op >= OP_WORD_INC) && (op <= OP_PTR_JUMP);
   assign prod_op = (op >= OP_UPROD) && (op <= OP_FMPROD);
   assign fin = (take & ~long_op) | (state_q == ST_SECOND);
   assign state_d = (take & long_op) ? ST_SECOND : ST_IDLE;

   // single cycle byte operations, flags computed beside the result
   always_comb begin
      ar = 11'h000;
      res8 = rd_val;
      c_n = 1'b0;
      h_n = 1'b0;
      v_n = 1'b0;
      z_keep = 1'b0;
      msk1 = `BALU_MSK_LOGIC;
      unique case (op)
         OP_ADD_REGS, OP_ADD_CARRY: begin
            ar = arith8(rd_val, src, (op == OP_ADD_CARRY) & carry_in, 1'b0);
            msk1 = `BALU_MSK_ARITH;
         end
         OP_SUB_REGS: begin
            ar = arith8(rd_val, src, 1'b0, 1'b1);
            msk1 = `BALU_MSK_ARITH;
         end
         // borrow subtract, zero only stays set across bytes
         OP_BORROW_DIFF: begin
            ar = arith8(rd_val, src, carry_in, 1'b1);
            z_keep = 1'b1;
            msk1 = `BALU_MSK_ARITH;
         end
         OP_CONJ, OP_ZS_TEST: res8 = op == OP_ZS_TEST ? rd_val : rd_val & src;
         OP_DISJ, OP_BIT_SET: res8 = rd_val | (op == OP_BIT_SET ? imm : src);
         OP_BIT_CLEAR: res8 = rd_val & (`BALU_ALL_ONES - imm);
         OP_XDISJ: res8 = rd_val ^ src;
         OP_ONES_INV: begin
            res8 = `BALU_ALL_ONES - rd_val;
            c_n = 1'b1;
            msk1 = `BALU_MSK_INVERT;
         end
         OP_ARITH_INV: begin
            ar = arith8(`BALU_ZERO_BYTE, rd_val, 1'b0, 1'b1);
            msk1 = `BALU_MSK_ARITH;
         end
         OP_PLUS_ONE, OP_MINUS_ONE: begin
            ar = arith8(rd_val, 8'h01, 1'b0, op == OP_MINUS_ONE);
            v_n = (op == OP_MINUS_ONE) ? (ar[7:0] == `BALU_MINUS_ONE_RES)
                                       : (ar[7:0] == `BALU_PLUS_ONE_RES);
         end
         OP_ONES_LOAD: begin
            res8 = `BALU_ALL_ONES;
            msk1 = `BALU_MSK_NONE;
         end
         default: msk1 = `BALU_MSK_NONE;
      endcase
      if (msk1 == `BALU_MSK_ARITH) begin
         res8 = ar[7:0];
         c_n = ar[8];
         v_n = ar[9];
         h_n = ar[10];
      end else if (op == OP_PLUS_ONE || op == OP_MINUS_ONE) begin
         res8 = ar[7:0];
      end
   end

   // flags image of a byte operation
   assign fl1[`BALU_FLAG_C] = c_n;
   assign fl1[`BALU_FLAG_Z] = (res8 == `BALU_ZERO_BYTE) &
                              (~z_keep | sreg_in[`BALU_FLAG_Z]);
   assign fl1[`BALU_FLAG_N] = res8[7];
   assign fl1[`BALU_FLAG_V] = v_n;
   assign fl1[`BALU_FLAG_S] = res8[7] ^ v_n;
   assign fl1[`BALU_FLAG_H] = h_n;
   assign fl1[7:6] = 2'b00;

   // word add or subtract of a six bit immediate on the register pair
   assign word_sum = (op == OP_WORD_DEC)
      ? ({1'b0, rd_hi_val, rd_val} - {11'h000, wimm})
      : ({1'b0, rd_hi_val, rd_val} + {11'h000, wimm});

   balu_mult u_mult (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .start(take & prod_op),
      .a(rd_val),
      .b(rr_val),
      .sign_a((op == OP_SPROD) || (op == OP_MPROD) ||
              (op == OP_FSPROD) || (op == OP_FMPROD)),
      .sign_b((op == OP_SPROD) || (op == OP_FSPROD)),
      .frac(op >= OP_FUPROD),
      .prod_q(prod),
      .carry_q(prod_c)
   );

   // first cycle of a long operation latches what the second one needs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         op_q <= OP_ADD_REGS;
         word_q <= `BALU_ZERO_WORD;
         wfl_q <= `BALU_ZERO_BYTE;
         sreg_lat_q <= `BALU_ZERO_BYTE;
         ptr_q <= `BALU_ZERO_WORD;
      end else begin
         state_q <= state_d;
         if (take) begin
            op_q <= op;
            word_q <= word_sum[15:0];
            wfl_q <= {3'b000,
               word_sum[15] ^ ((op == OP_WORD_DEC)
                  ? (rd_hi_val[7] & ~word_sum[15])
                  : (~rd_hi_val[7] & word_sum[15])),
               (op == OP_WORD_DEC) ? (rd_hi_val[7] & ~word_sum[15])
                                   : (~rd_hi_val[7] & word_sum[15]),
               word_sum[15],
               word_sum[15:0] == `BALU_ZERO_WORD,
               (op == OP_WORD_DEC) ? (word_sum[15] & ~rd_hi_val[7])
                                   : (~word_sum[15] & rd_hi_val[7])};
            sreg_lat_q <= sreg_in;
            ptr_q <= ptr_val;
         end
      end
   end

   assign out_pair = (state_q == ST_SECOND) && (op_q != OP_WORD_INC) &&
                     (op_q != OP_WORD_DEC) && (op_q != OP_PTR_JUMP);
   assign out_jump = (state_q == ST_SECOND) && (op_q == OP_PTR_JUMP);
   assign out_lo = (state_q == ST_IDLE) ? res8 :
                   out_pair ? prod[7:0] : word_q[7:0];
   assign out_hi = out_pair ? prod[15:8] : word_q[15:8];
   assign out_fl = (state_q == ST_IDLE) ? fl1 : out_pair
      ? {6'h00, prod == `BALU_ZERO_WORD, prod_c} : wfl_q;
   assign out_msk = (state_q == ST_IDLE) ? msk1 : out_jump
      ? `BALU_MSK_NONE : out_pair ? `BALU_MSK_PROD : `BALU_MSK_WORD;
   assign out_wr_lo = (state_q == ST_IDLE) ? (op != OP_ZS_TEST) : ~out_jump;
   assign out_wr_hi = (state_q == ST_SECOND) & ~out_jump;
   assign base = (state_q == ST_IDLE) ? sreg_in : sreg_lat_q;

   // merge new flags over the status image, bit by bit
   generate
      for (genvar i = 0; i < 8; i++) begin : g_merge
         assign sreg_d[i] = out_msk[i] ? out_fl[i] : base[i];
      end
   endgenerate

   // result registers; strobes pulse for one cycle with done
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         done_q <= 1'b0;
         wr_lo_q <= 1'b0;
         wr_hi_q <= 1'b0;
         to_pair_q <= 1'b0;
         pc_load_q <= 1'b0;
         res_lo_q <= `BALU_ZERO_BYTE;
         res_hi_q <= `BALU_ZERO_BYTE;
         sreg_q <= `BALU_ZERO_BYTE;
         sreg_we_q <= `BALU_ZERO_BYTE;
         pc_q <= `BALU_ZERO_WORD;
      end else begin
         done_q <= fin;
         wr_lo_q <= fin & out_wr_lo;
         wr_hi_q <= fin & out_wr_hi;
         pc_load_q <= fin & out_jump;
         if (fin) begin
            to_pair_q <= out_pair;
            res_lo_q <= out_lo;
            res_hi_q <= out_hi;
            sreg_q <= sreg_d;
            sreg_we_q <= out_msk;
            pc_q <= ptr_q;
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_add_one;
      take && op == OP_ADD_REGS |=> done_q && wr_lo_q &&
         res_lo_q == 8'($past(rd_val) + $past(src));
   endproperty
   a_add_one: assert property (p_add_one)
      else $error("add result wrong");

   property p_word_inc;
      take && op == OP_WORD_INC |=> !done_q ##1 done_q && wr_hi_q &&
         {res_hi_q, res_lo_q} == 16'({$past(rd_hi_val, 2),
         $past(rd_val, 2)} + {10'h000, $past(wimm, 2)});
   endproperty
   a_word_inc: assert property (p_word_inc)
      else $error("word add wrong or not two cycles");

   property p_sub_one;
      take && op == OP_SUB_REGS |=> done_q &&
         sreg_we_q == `BALU_MSK_ARITH &&
         res_lo_q == 8'($past(rd_val) - $past(src));
   endproperty
   a_sub_one: assert property (p_sub_one)
      else $error("subtract wrong");

   property p_word_dec;
      take && op == OP_WORD_DEC |-> ##2 done_q &&
         sreg_we_q == `BALU_MSK_WORD;
   endproperty
   a_word_dec: assert property (p_word_dec)
      else $error("word subtract flags or timing wrong");

   property p_conj;
      take && op == OP_CONJ |=> res_lo_q == ($past(rd_val) & $past(src))
         && !sreg_q[`BALU_FLAG_V];
   endproperty
   a_conj: assert property (p_conj)
      else $error("conjunction wrong");

   property p_bit_clear;
      take && op == OP_BIT_CLEAR |=>
         res_lo_q == ($past(rd_val) & ~$past(imm));
   endproperty
   a_bit_clear: assert property (p_bit_clear)
      else $error("bit clear wrong");

   property p_uprod;
      take && op == OP_UPROD |=> ##1 done_q && to_pair_q &&
         {res_hi_q, res_lo_q} ==
         ({8'h00, $past(rd_val, 2)} * {8'h00, $past(rr_val, 2)});
   endproperty
   a_uprod: assert property (p_uprod)
      else $error("unsigned product wrong");

   property p_jump;
      take && op == OP_PTR_JUMP |=> !done_q ##1 done_q && pc_load_q &&
         pc_q == $past(ptr_val, 2) && sreg_we_q == `BALU_MSK_NONE;
   endproperty
   a_jump: assert property (p_jump)
      else $error("pointer jump wrong");

   property p_xdisj;
      take && op == OP_XDISJ |=> res_lo_q == ($past(rd_val) ^ $past(src));
   endproperty
   a_xdisj: assert property (p_xdisj)
      else $error("exclusive or wrong");

   property p_ones_load;
      take && op == OP_ONES_LOAD |=> res_lo_q == `BALU_ALL_ONES &&
         sreg_we_q == `BALU_MSK_NONE && sreg_q == $past(sreg_in);
   endproperty
   a_ones_load: assert property (p_ones_load)
      else $error("all ones load wrong");
endmodule

// ==== design/balu_params.svh ====
`ifndef BALU_PARAMS_SVH
`define BALU_PARAMS_SVH

// status image bit positions
`define BALU_FLAG_C 0
`define BALU_FLAG_Z 1
`define BALU_FLAG_N 2
`define BALU_FLAG_V 3
`define BALU_FLAG_S 4
`define BALU_FLAG_H 5

// flag update masks, one bit per status image position
`define BALU_MSK_ARITH 8'h2F
`define BALU_MSK_LOGIC 8'h0E
`define BALU_MSK_INVERT 8'h0F
`define BALU_MSK_WORD 8'h1F
`define BALU_MSK_PROD 8'h03
`define BALU_MSK_NONE 8'h00

// byte and word constants
`define BALU_ALL_ONES 8'hFF
`define BALU_ZERO_BYTE 8'h00
`define BALU_ZERO_WORD 16'h0000
`define BALU_MINUS_ONE_RES 8'h7F
`define BALU_PLUS_ONE_RES 8'h80

// timing in clock cycles
`define BALU_SHORT_CYCLES 1
`define BALU_LONG_CYCLES 2

`endif

// ==== design/balu_pkg.sv ====
package balu_pkg;

   // operation select
   typedef enum logic [4:0] {
      OP_ADD_REGS    = 5'h00,
      OP_ADD_CARRY   = 5'h01,
      OP_SUB_REGS    = 5'h02,
      OP_BORROW_DIFF = 5'h03,
      OP_CONJ        = 5'h04,
      OP_DISJ        = 5'h05,
      OP_XDISJ       = 5'h06,
      OP_BIT_SET     = 5'h07,
      OP_BIT_CLEAR   = 5'h08,
      OP_ZS_TEST     = 5'h09,
      OP_ONES_INV    = 5'h0A,
      OP_ARITH_INV   = 5'h0B,
      OP_PLUS_ONE    = 5'h0C,
      OP_MINUS_ONE   = 5'h0D,
      OP_ONES_LOAD   = 5'h0E,
      OP_WORD_INC    = 5'h0F,
      OP_WORD_DEC    = 5'h10,
      OP_UPROD       = 5'h11,
      OP_SPROD       = 5'h12,
      OP_MPROD       = 5'h13,
      OP_FUPROD      = 5'h14,
      OP_FSPROD      = 5'h15,
      OP_FMPROD      = 5'h16,
      OP_PTR_JUMP    = 5'h17
   } balu_op_e;

   // sequencer states
   typedef enum logic [0:0] {
      ST_IDLE   = 1'b0,
      ST_SECOND = 1'b1
   } balu_state_e;

endpackage

// ==== design/balu_mult.sv ====
`timescale 1ns/1ps
module balu_mult (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic sign_a,
   input wire logic sign_b,
   input wire logic frac,
   output logic [15:0] prod_q,
   output logic carry_q
);
   logic signed [8:0] ext_a;
   logic signed [8:0] ext_b;
   logic signed [17:0] full;
   logic [15:0] raw;

   // one extra bit lets a single signed multiplier serve all three signs
   assign ext_a = {sign_a & a[7], a};
   assign ext_b = {sign_b & b[7], b};
   assign full = ext_a * ext_b;
   assign raw = full[15:0];

   // carry is taken before the fractional shift drops the top bit
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prod_q <= 16'h0000;
         carry_q <= 1'b0;
      end else if (start) begin
         prod_q <= frac ? {raw[14:0], 1'b0} : raw;
         carry_q <= raw[15];
      end
   end
endmodule

// ==== tb/balu_top_test.sv ====
`timescale 1ns/1ps
module balu_top_test;
   import balu_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic start = 1'b0;
   balu_op_e op = OP_ADD_REGS;
   logic use_const = 1'b0;
   logic [7:0] rd_val = 8'h00;
   logic [7:0] rd_hi_val = 8'h00;
   logic [7:0] rr_val = 8'h00;
   logic [7:0] imm = 8'h00;
   logic [7:0] sreg_in = 8'h00;
   logic [15:0] ptr_val = 16'h0000;
   logic ready, done_q, wr_lo_q, wr_hi_q, to_pair_q, pc_load_q;
   logic [7:0] res_lo_q, res_hi_q, sreg_q, sreg_we_q;
   logic [15:0] pc_q;
   int num_errors = 0;
   int tests_run = 0;

   // 200 MHz system clock
   always #2.5 clk_sys = ~clk_sys;

   balu_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .start(start), .op(op),
      .use_const(use_const), .rd_val(rd_val), .rd_hi_val(rd_hi_val),
      .rr_val(rr_val), .imm(imm), .sreg_in(sreg_in), .ptr_val(ptr_val),
      .ready(ready), .done_q(done_q), .res_lo_q(res_lo_q),
      .res_hi_q(res_hi_q), .wr_lo_q(wr_lo_q), .wr_hi_q(wr_hi_q),
      .to_pair_q(to_pair_q), .sreg_q(sreg_q), .sreg_we_q(sreg_we_q),
      .pc_load_q(pc_load_q), .pc_q(pc_q));

   task end_sim;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one request: pair is hi:lo destination and also the pointer value
   task run(input balu_op_e o, input logic uc, input logic [15:0] pr,
      input logic [7:0] rr, input logic [7:0] k, input logic [7:0] sr,
      input logic [15:0] eres, input logic [7:0] em, input logic [7:0] ef);
      logic lng;
      lng = (o >= OP_WORD_INC);
      @(posedge clk_sys);
      op <= o;
      use_const <= uc;
      {rd_hi_val, rd_val} <= pr;
      ptr_val <= pr;
      rr_val <= rr;
      imm <= k;
      sreg_in <= sr;
      start <= 1'b1;
      #1;
      chk({15'h0, done_q}, 16'h0000);
      // taken at this edge; short ops answer right after it
      @(posedge clk_sys);
      start <= 1'b0;
      // long ops hold ready low for one cycle and answer exactly one later
      if (lng) begin
         #1;
         chk({15'h0, ready}, 16'h0000);
         chk({15'h0, done_q}, 16'h0000);
         @(posedge clk_sys);
      end
      #1;
      chk({15'h0, done_q}, 16'h0001);
      chk({8'h00, sreg_we_q}, {8'h00, em});
      chk({8'h00, sreg_q & em}, {8'h00, ef});
      // flags outside the mask must come back untouched
      chk({8'h00, sreg_q & ~em & 8'h3F}, {8'h00, sr & ~em & 8'h3F});
      chk({15'h0, wr_lo_q}, {15'h0, o != OP_ZS_TEST && o != OP_PTR_JUMP});
      if (o == OP_PTR_JUMP) begin
         chk(pc_q, eres);
         chk({15'h0, pc_load_q}, 16'h0001);
      end else if (lng) begin
         chk({res_hi_q, res_lo_q}, eres);
         chk({15'h0, wr_hi_q}, 16'h0001);
         chk({15'h0, to_pair_q}, {15'h0, o >= OP_UPROD});
      end else begin
         chk({8'h00, res_lo_q}, eres);
      end
   endtask

   task t_add;
      run(OP_ADD_REGS, 1'h0, 16'h000F, 8'h01, 8'h00, 8'h00,
         16'h0010, 8'h2F, 8'h20);
      run(OP_ADD_CARRY, 1'h0, 16'h00FF, 8'h00, 8'h00, 8'h01,
         16'h0000, 8'h2F, 8'h23);
   endtask

   task t_sub;
      run(OP_SUB_REGS, 1'h1, 16'h0000, 8'h77, 8'h01, 8'h00,
         16'h00FF, 8'h2F, 8'h25);
      run(OP_BORROW_DIFF, 1'h0, 16'h0080, 8'h00, 8'h55, 8'h03,
         16'h007F, 8'h2F, 8'h28);
      run(OP_BORROW_DIFF, 1'h1, 16'h0010, 8'h44, 8'h10, 8'h02,
         16'h0000, 8'h2F, 8'h02);
      run(OP_BORROW_DIFF, 1'h1, 16'h0010, 8'h44, 8'h10, 8'h00,
         16'h0000, 8'h2F, 8'h00);
   endtask

   task t_logic;
      run(OP_CONJ, 1'h0, 16'h00F0, 8'h3C, 8'hFF, 8'h08,
         16'h0030, 8'h0E, 8'h00);
      run(OP_CONJ, 1'h1, 16'h00F0, 8'hFF, 8'h0F, 8'h00,
         16'h0000, 8'h0E, 8'h02);
      run(OP_DISJ, 1'h0, 16'h0080, 8'h01, 8'h00, 8'h00,
         16'h0081, 8'h0E, 8'h04);
      run(OP_DISJ, 1'h1, 16'h0000, 8'hFF, 8'h00, 8'h00,
         16'h0000, 8'h0E, 8'h02);
      run(OP_XDISJ, 1'h0, 16'h005A, 8'h5A, 8'h00, 8'h08,
         16'h0000, 8'h0E, 8'h02);
      run(OP_BIT_SET, 1'h0, 16'h0001, 8'h00, 8'h80, 8'h00,
         16'h0081, 8'h0E, 8'h04);
      run(OP_BIT_CLEAR, 1'h0, 16'h00FF, 8'hFF, 8'h0F, 8'h00,
         16'h00F0, 8'h0E, 8'h04);
      run(OP_ZS_TEST, 1'h0, 16'h0080, 8'h00, 8'h00, 8'h3B,
         16'h0080, 8'h0E, 8'h04);
   endtask

   task t_unary;
      run(OP_ONES_INV, 1'h0, 16'h0055, 8'h00, 8'h00, 8'h00,
         16'h00AA, 8'h0F, 8'h05);
      run(OP_ARITH_INV, 1'h0, 16'h0001, 8'h00, 8'h00, 8'h00,
         16'h00FF, 8'h2F, 8'h25);
      run(OP_PLUS_ONE, 1'h0, 16'h007F, 8'h00, 8'h00, 8'h21,
         16'h0080, 8'h0E, 8'h0C);
      run(OP_MINUS_ONE, 1'h0, 16'h0080, 8'h00, 8'h00, 8'h00,
         16'h007F, 8'h0E, 8'h08);
      run(OP_ONES_LOAD, 1'h0, 16'h0012, 8'h00, 8'h00, 8'h2A,
         16'h00FF, 8'h00, 8'h00);
   endtask

   // word arithmetic, upper constant bits ignored
   task t_word;
      run(OP_WORD_INC, 1'h1, 16'hFFFF, 8'h00, 8'hC1, 8'h00,
         16'h0000, 8'h1F, 8'h03);
      run(OP_WORD_DEC, 1'h1, 16'h8000, 8'h00, 8'h01, 8'h20,
         16'h7FFF, 8'h1F, 8'h18);
   endtask

   task t_prod;
      run(OP_UPROD, 1'h0, 16'h00FF, 8'hFF, 8'h00, 8'h00,
         16'hFE01, 8'h03, 8'h01);
      run(OP_SPROD, 1'h0, 16'h00FF, 8'hFF, 8'h00, 8'h03,
         16'h0001, 8'h03, 8'h00);
      run(OP_MPROD, 1'h0, 16'h00FF, 8'hFF, 8'h00, 8'h00,
         16'hFF01, 8'h03, 8'h01);
      run(OP_UPROD, 1'h0, 16'h0000, 8'h37, 8'h00, 8'h00,
         16'h0000, 8'h03, 8'h02);
      run(OP_FUPROD, 1'h0, 16'h0080, 8'h80, 8'h00, 8'h00,
         16'h8000, 8'h03, 8'h00);
      run(OP_FSPROD, 1'h0, 16'h0080, 8'h80, 8'h00, 8'h01,
         16'h8000, 8'h03, 8'h00);
      run(OP_FMPROD, 1'h0, 16'h00C0, 8'h80, 8'h00, 8'h00,
         16'hC000, 8'h03, 8'h01);
   endtask

   task t_jump;
      run(OP_PTR_JUMP, 1'h0, 16'hA5C3, 8'h00, 8'h00, 8'h3F,
         16'hA5C3, 8'h00, 8'h00);
   endtask

   // start held while ready is low must be ignored
   task t_refuse;
      @(posedge clk_sys);
      op <= OP_WORD_INC;
      use_const <= 1'b1;
      {rd_hi_val, rd_val} <= 16'h00FE;
      rr_val <= 8'hFE;
      imm <= 8'h01;
      sreg_in <= 8'h00;
      start <= 1'b1;
      @(posedge clk_sys);
      // a wrongly taken second request would xor FE with imm 01, leaving the low byte FF
      op <= OP_XDISJ;
      @(posedge clk_sys);
      start <= 1'b0;
      #1;
      chk({15'h0, done_q}, 16'h0001);
      chk({res_hi_q, res_lo_q}, 16'h00FF);
      @(posedge clk_sys);
      #1;
      chk({15'h0, done_q}, 16'h0000);
      chk({8'h00, res_lo_q}, 16'h00FF);
   endtask

   // cut a hang short well past the expected run length
   initial begin
      #5000;
      num_errors++;
      $display("watchdog expired");
      end_sim;
   end

   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      chk({14'h0, ready, done_q}, 16'h0002);
      t_add;
      t_sub;
      t_logic;
      t_unary;
      t_word;
      t_prod;
      t_jump;
      t_refuse;
      end_sim;
   end
endmodule
